// file: design/muting_cfg.svh
// Notes on behaviour
// RULE1 - Concurrent: both pair sensors within pairing window
// RULE2 - Concurrent/sequential start: sensors clear, curtain free
// RULE3 - L/T start: pair clear, curtain free
// RULE4 - Cycle timeout withdraws muting; zero means unlimited
// RULE5 - Without enable option, function always enabled
// RULE6 - Enable/disable: start only after enable rise
// RULE7 - Enable/disable: enable fall ends muting at once
// RULE8 - Enable-only: enabler drops enable before re-arming
// RULE9 - Concurrent direction: up, down or two-way
// RULE10 - Sequential direction: first-to-fourth, reverse or both
// RULE11 - Curtain closing: entry clear, then curtain high
// RULE12 - Sensor closing: third sensor in order clears
// RULE13 - Blind time forces curtain high after close; here only in L/T mode or after curtain closing, never after sensor closing
// RULE14 - Refuse start when pairing time exceeded
// RULE15 - Minimum pairing: more than 150 ms apart
// RULE16 - L mode ends when curtain released
// RULE17 - L mode end timer from first release
// RULE18 - Sequential order one-two-three-four, or reverse
// RULE19 - T mode ends when one sensor releases
// RULE20 - Muting bypasses curtain until cycle closes
// RULE21 - Output is curtain OR blind OR muting
// RULE22 - Abnormal end returns idle, preconditions again
`ifndef MUTING_CFG_SVH
`define MUTING_CFG_SVH

`define CLK_HZ         25000000
`define TICK_US        1000
`define US_PER_S       1000000

`define ADR_CTRL       8'h00
`define ADR_TIME0      8'h04
`define ADR_TIME1      8'h08
`define ADR_TIME2      8'h0C
`define ADR_STATUS     8'h10

`define CTRL_RST       32'h0000_0000
`define TIME0_RST      32'h09C4_07D0
`define TIME1_RST      32'h0000_0000
`define TIME2_RST      32'h0000_00FA

`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_WITH_EN   2
`define CTRL_EN_ONLY   3
`define CTRL_DIR_LO    4
`define CTRL_DIR_HI    5
`define CTRL_SNS_CLOSE 6
`define CTRL_BLIND_EN  7
`define CTRL_MIN_PAIR  8

`define T0_PAIR_HI     15
`define T0_EOM_LO      16
`define T1_TMO_HI      23
`define T2_BLIND_HI    15

`define PAIR_MIN_MS    24'h00_07D0
`define PAIR_MAX_MS    24'h00_1388
`define EOM_MIN_MS     24'h00_09C4
`define EOM_MAX_MS     24'h00_1770
`define TMO_MIN_MS     24'h00_2710
`define TMO_MAX_MS     24'hFF_FFFF
`define BLIND_MIN_MS   24'h00_00FA
`define BLIND_MAX_MS   24'h00_03E8
`define MIN_PAIR_MS    24'h00_0096
`define MS_ZERO        24'h00_0000
`define MS_ONE         24'h00_0001

`endif

// file: design/muting_pkg.sv
package muting_pkg;

  typedef enum logic [1:0] {MODE_CONC, MODE_L, MODE_SEQ, MODE_T} mode_t;
  typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_TWO_WAY, DIR_SPARE} dir_t;
  typedef enum logic [2:0] {ST_IDLE, ST_READY, ST_PAIR, ST_MUTE, ST_BLIND} state_t;

  typedef struct packed {
    mode_t mode;
    logic  with_en;
    logic  en_only;
    dir_t  dir;
    logic  sensor_close;
    logic  blind_en;
    logic  min_pair;
  } ctrl_t;

  typedef struct packed {
    logic [23:0] pair_ms;
    logic [23:0] eom_ms;
    logic [23:0] tmo_ms;
    logic [23:0] blind_ms;
  } times_t;

  // Sensors: [0] entry_sensor_a, [1] entry_sensor_b, [2] exit_sensor_a, [3] exit_sensor_b
  typedef struct packed {
    logic       enable;
    logic       curtain;
    logic [3:0] sensor;
  } pins_t;

endpackage

// file: design/muting_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "muting_cfg.svh"

module muting_sequencer #(
  parameter int unsigned TICK_CYC = `CLK_HZ / `US_PER_S * `TICK_US
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Field pins
  input  wire logic        i_entry_sensor_a,
  input  wire logic        i_entry_sensor_b,
  input  wire logic        i_exit_sensor_a,
  input  wire logic        i_exit_sensor_b,
  input  wire logic        i_curtain,
  input  wire logic        i_enable,
  // Results
  output logic             o_safety_ok,
  output logic             o_muting_active,
  output logic             o_blind_active
);

  function automatic logic [23:0] clamp(input logic [23:0] v, input logic [23:0] lo,
                                        input logic [23:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Register bus
  logic [31:0] ctrl_ff;
  logic [31:0] time0_ff;
  logic [31:0] time1_ff;
  logic [31:0] time2_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic        wb_req;
  logic [31:0] status;

  assign wb_req   = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_req;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_ff  <= `CTRL_RST;
      time0_ff <= `TIME0_RST;
      time1_ff <= `TIME1_RST;
      time2_ff <= `TIME2_RST;
    end
    else if (wb_req && i_wb_we)
    begin
      unique case (i_wb_adr)
        `ADR_CTRL:  ctrl_ff  <= merge(ctrl_ff, i_wb_dat, i_wb_sel);
        `ADR_TIME0: time0_ff <= merge(time0_ff, i_wb_dat, i_wb_sel);
        `ADR_TIME1: time1_ff <= merge(time1_ff, i_wb_dat, i_wb_sel);
        `ADR_TIME2: time2_ff <= merge(time2_ff, i_wb_dat, i_wb_sel);
        default:    ;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rdat_ff <= 32'h0000_0000;
    else if (wb_req && !i_wb_we)
    begin
      unique case (i_wb_adr)
        `ADR_CTRL:   rdat_ff <= ctrl_ff;
        `ADR_TIME0:  rdat_ff <= time0_ff;
        `ADR_TIME1:  rdat_ff <= time1_ff;
        `ADR_TIME2:  rdat_ff <= time2_ff;
        `ADR_STATUS: rdat_ff <= status;
        default:     rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration decode; out-of-range times are pulled into range
  muting_pkg::ctrl_t  cfg;
  muting_pkg::times_t tms;

  assign cfg.mode         = muting_pkg::mode_t'(ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign cfg.with_en      = ctrl_ff[`CTRL_WITH_EN];
  assign cfg.en_only      = ctrl_ff[`CTRL_EN_ONLY];
  assign cfg.dir          = muting_pkg::dir_t'(ctrl_ff[`CTRL_DIR_HI:`CTRL_DIR_LO]);
  assign cfg.sensor_close = ctrl_ff[`CTRL_SNS_CLOSE];
  assign cfg.blind_en     = ctrl_ff[`CTRL_BLIND_EN];
  assign cfg.min_pair     = ctrl_ff[`CTRL_MIN_PAIR];
  assign tms.pair_ms  = clamp({8'h00, time0_ff[`T0_PAIR_HI:0]}, `PAIR_MIN_MS, `PAIR_MAX_MS);
  assign tms.eom_ms   = clamp({8'h00, time0_ff[31:`T0_EOM_LO]}, `EOM_MIN_MS, `EOM_MAX_MS);
  assign tms.blind_ms = clamp({8'h00, time2_ff[`T2_BLIND_HI:0]}, `BLIND_MIN_MS, `BLIND_MAX_MS);
  // Zero keeps the timeout unlimited; any other value is at least the floor
  assign tms.tmo_ms   = (time1_ff[`T1_TMO_HI:0] == `MS_ZERO) ? `MS_ZERO :
                        clamp(time1_ff[`T1_TMO_HI:0], `TMO_MIN_MS, `TMO_MAX_MS);

  // Pin synchronisers
  muting_pkg::pins_t sy1_ff;
  muting_pkg::pins_t sy2_ff;
  logic              en_d_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sy1_ff  <= '0;
      sy2_ff  <= '0;
      en_d_ff <= 1'b0;
    end
    else
    begin
      sy1_ff  <= {i_enable, i_curtain, i_exit_sensor_b, i_exit_sensor_a,
                  i_entry_sensor_b, i_entry_sensor_a};
      sy2_ff  <= sy1_ff;
      en_d_ff <= sy2_ff.enable;
    end
  end

  logic [3:0] s;
  logic       curtain;
  logic       en_rise;
  logic       en_fall;

  assign s       = sy2_ff.sensor;
  assign curtain = sy2_ff.curtain;
  assign en_rise = sy2_ff.enable & ~en_d_ff;
  assign en_fall = ~sy2_ff.enable & en_d_ff;

  // Millisecond time base; all timers count these ticks
  logic [15:0] div_ff;
  logic        tick;

  assign tick = (div_ff == 16'(TICK_CYC - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || tick)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // Sequencer
  muting_pkg::state_t state_ff;
  muting_pkg::state_t nxt_state;
  logic               up_ff;
  logic               nxt_up;
  logic               third_ff;
  logic               nxt_third;
  logic               rel_ff;
  logic               nxt_rel;
  logic               low_ff;
  logic               nxt_low;
  logic               armed_ff;
  logic [23:0]        tmr_ff;
  logic [23:0]        cyc_ff;
  logic               tmr_clr;
  logic               consume;
  logic               pre_ok;
  logic               armed;
  logic               two_ch;
  logic               allow_up;
  logic               allow_down;
  logic [1:0]         lead;
  logic               third;
  logic               ed_mode;
  logic               close;
  logic               blind_ok;

  assign two_ch     = (cfg.mode == muting_pkg::MODE_L) || (cfg.mode == muting_pkg::MODE_T);
  assign ed_mode    = cfg.with_en & ~cfg.en_only;
  // RULE5 permanent enable
  assign armed      = ~cfg.with_en | armed_ff;
  // RULE2 four-sensor start
  // RULE3 pair start
  assign pre_ok     = curtain && (two_ch ? (s[1:0] == 2'b00) : (s == 4'b0000));
  // RULE9 concurrent direction
  // RULE10 sequential direction
  assign allow_up   = two_ch || (cfg.dir != muting_pkg::DIR_DOWN);
  assign allow_down = !two_ch && (cfg.dir != muting_pkg::DIR_UP);
  assign lead       = up_ff ? s[1:0] : s[3:2];
  assign third      = up_ff ? s[2] : s[1];
  // RULE13 blind gating
  assign blind_ok   = cfg.blind_en && (two_ch || !cfg.sensor_close);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_up    = up_ff;
    nxt_third = third_ff;
    nxt_rel   = rel_ff;
    nxt_low   = low_ff;
    tmr_clr   = 1'b0;
    consume   = 1'b0;
    close     = 1'b0;
    unique case (state_ff)
      muting_pkg::ST_IDLE:
      begin
        // RULE22 preconditions again
        if (pre_ok)
          nxt_state = muting_pkg::ST_READY;
      end
      muting_pkg::ST_READY:
      begin
        if (!armed && !pre_ok)
          nxt_state = muting_pkg::ST_IDLE;
        // RULE18 sequential entry
        else if (armed && allow_up && (cfg.mode == muting_pkg::MODE_SEQ ?
                 (s == 4'b0001) : (s[1:0] != 2'b00 && s[3:2] == 2'b00)))
        begin
          nxt_state = muting_pkg::ST_PAIR;
          nxt_up    = 1'b1;
        end
        else if (armed && allow_down && (cfg.mode == muting_pkg::MODE_SEQ ?
                 (s == 4'b1000) : (s[3:2] != 2'b00 && s[1:0] == 2'b00)))
        begin
          nxt_state = muting_pkg::ST_PAIR;
          nxt_up    = 1'b0;
        end
        else if (!pre_ok)
          nxt_state = muting_pkg::ST_IDLE;
      end
      muting_pkg::ST_PAIR:
      begin
        nxt_third = 1'b0;
        nxt_rel   = 1'b0;
        nxt_low   = 1'b0;
        // RULE1 pair complete
        if (lead == 2'b11)
        begin
          // RULE15 minimum pairing
          if (cfg.min_pair && cfg.mode == muting_pkg::MODE_CONC && tmr_ff <= `MIN_PAIR_MS)
            nxt_state = muting_pkg::ST_IDLE;
          else
          begin
            nxt_state = muting_pkg::ST_MUTE;
            consume   = 1'b1;
          end
        end
        // RULE14 pairing time exceeded
        else if (lead == 2'b00 || !curtain || tmr_ff >= tms.pair_ms)
          nxt_state = muting_pkg::ST_IDLE;
      end
      muting_pkg::ST_MUTE:
      begin
        if (third)
          nxt_third = 1'b1;
        if (!curtain)
          nxt_low = 1'b1;
        if (!rel_ff && s[1:0] != 2'b11)
        begin
          nxt_rel = 1'b1;
          tmr_clr = 1'b1;
        end
        unique case (cfg.mode)
          // RULE19 T release
          muting_pkg::MODE_T: close = (s[1:0] != 2'b11);
          // RULE16 curtain released
          // RULE17 end timer
          muting_pkg::MODE_L: close = rel_ff && ((low_ff && curtain) || tmr_ff >= tms.eom_ms);
          default:
          begin
            // RULE12 third clears
            if (cfg.sensor_close)
              close = third_ff && !third;
            // RULE11 curtain closing
            else
              close = (lead == 2'b00) && curtain;
          end
        endcase
        // RULE4 cycle timeout
        if (tms.tmo_ms != `MS_ZERO && cyc_ff >= tms.tmo_ms)
          nxt_state = muting_pkg::ST_IDLE;
        else if (close)
        begin
          nxt_state = blind_ok ? muting_pkg::ST_BLIND : muting_pkg::ST_IDLE;
          tmr_clr   = 1'b1;
        end
      end
      muting_pkg::ST_BLIND:
      begin
        if (tmr_ff >= tms.blind_ms)
          nxt_state = muting_pkg::ST_IDLE;
      end
      default:
        nxt_state = muting_pkg::ST_IDLE;
    endcase
    // RULE7 disable on fall
    if (ed_mode && en_fall)
      nxt_state = muting_pkg::ST_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_ff <= muting_pkg::ST_IDLE;
      up_ff    <= 1'b1;
      third_ff <= 1'b0;
      rel_ff   <= 1'b0;
      low_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      up_ff    <= nxt_up;
      third_ff <= nxt_third;
      rel_ff   <= nxt_rel;
      low_ff   <= nxt_low;
    end
  end

  // RULE6 arm on rising edge
  // RULE8 enabler must drop
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      armed_ff <= 1'b0;
    else if (cfg.with_en && en_rise)
      armed_ff <= 1'b1;
    else if (consume || en_fall || !cfg.with_en)
      armed_ff <= 1'b0;
  end

  // RULE4/RULE13/RULE14/RULE17 tick timers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || tmr_clr || nxt_state != state_ff)
      tmr_ff <= `MS_ZERO;
    else if (tick && tmr_ff != `TMO_MAX_MS)
      tmr_ff <= tmr_ff + `MS_ONE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_ff != muting_pkg::ST_MUTE)
      cyc_ff <= `MS_ZERO;
    else if (tick && cyc_ff != `TMO_MAX_MS)
      cyc_ff <= cyc_ff + `MS_ONE;
  end

  // Outputs follow the next state so the bypass lands with the state change
  logic safety_ff;
  logic mute_ff;
  logic blind_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      safety_ff <= 1'b0;
      mute_ff   <= 1'b0;
      blind_ff  <= 1'b0;
    end
    else
    begin
      mute_ff   <= (nxt_state == muting_pkg::ST_MUTE);
      blind_ff  <= (nxt_state == muting_pkg::ST_BLIND);
      // RULE20 curtain bypass
      // RULE21 output OR
      safety_ff <= curtain | (nxt_state == muting_pkg::ST_MUTE) |
                   (nxt_state == muting_pkg::ST_BLIND);
    end
  end

  assign o_safety_ok     = safety_ff;
  assign o_muting_active = mute_ff;
  assign o_blind_active  = blind_ff;

  assign status = {20'h0_0000, armed_ff, up_ff, curtain, s, blind_ff, mute_ff, 3'(state_ff)};

endmodule
`default_nettype wire

// file: test/muting_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module muting_field_model (
  // Clock
  input  wire logic              i_clk,
  // Sensors, curtain and enable
  output var muting_pkg::pins_t  o_pins
);
  initial o_pins = 6'h10;

  task automatic put(input muting_pkg::pins_t p);
    @(posedge i_clk);
    o_pins <= p;
  endtask

  task automatic arm();
    put(o_pins & 6'h1F);
    put(o_pins | 6'h20);
  endtask
endmodule
`default_nettype wire

// file: test/muting_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module muting_sequencer_assertions #(
  parameter int unsigned TICK_CYC = 25000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Bus
  input  wire logic i_wb_cyc,
  input  wire logic i_wb_stb,
  input  wire logic o_wb_ack,
  // Field pins
  input  wire logic i_entry_sensor_a,
  input  wire logic i_entry_sensor_b,
  input  wire logic i_exit_sensor_a,
  input  wire logic i_exit_sensor_b,
  input  wire logic i_curtain,
  // Results
  input  wire logic o_safety_ok,
  input  wire logic o_muting_active,
  input  wire logic o_blind_active
);
  // Longest blind setting plus pipeline slack
  localparam int BLIND_LIM = 1000 * TICK_CYC + 4;
  logic [2:0]  age_ff;
  logic [31:0] blind_cnt_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Curtain history is only trusted once the sync flops refilled
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      age_ff <= 3'h0;
    else if (age_ff != 3'h4)
      age_ff <= age_ff + 3'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !o_blind_active)
      blind_cnt_ff <= 32'h0000_0000;
    else
      blind_cnt_ff <= blind_cnt_ff + 32'h0000_0001;
  end

  AST_SAFE_OR:
    assert property ((age_ff == 3'h4) |->
      o_safety_ok == ($past(i_curtain, 3) | o_muting_active | o_blind_active))
    else $error("safety output is not curtain or muting or blind");
  AST_MUTE_SAFE:
    assert property (o_muting_active |-> o_safety_ok)
    else $error("safety output low while muting");
  AST_MUTE_PAIR:
    assert property ($rose(o_muting_active) |->
      $past(i_entry_sensor_a && i_entry_sensor_b, 3) ||
      $past(i_exit_sensor_a && i_exit_sensor_b, 3))
    else $error("muting started without an occupied pair");
  AST_EXCL:
    assert property (!(o_muting_active && o_blind_active))
    else $error("muting and blind at once");
  AST_BLIND_AFTER:
    assert property ($rose(o_blind_active) |-> $past(o_muting_active))
    else $error("blind started without a closing cycle");
  AST_BLIND_LEN:
    assert property (blind_cnt_ff <= 32'(BLIND_LIM))
    else $error("blind interval too long");
  AST_ACK_TAKE:
    assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  AST_ACK_ONE:
    assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE:
    assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");

  cover property ($rose(o_muting_active));
  cover property ($rose(o_blind_active));
  cover property (o_muting_active && !i_curtain);
endmodule

bind muting_sequencer muting_sequencer_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_entry_sensor_a(i_entry_sensor_a),
  .i_entry_sensor_b(i_entry_sensor_b), .i_exit_sensor_a(i_exit_sensor_a),
  .i_exit_sensor_b(i_exit_sensor_b), .i_curtain(i_curtain), .o_safety_ok(o_safety_ok),
  .o_muting_active(o_muting_active), .o_blind_active(o_blind_active));
`default_nettype wire

// file: test/muting_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module muting_sequencer_tb;
  // Short tick keeps second-long timers affordable
  localparam int unsigned TICK = 2;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0000_0000;
  logic [31:0]       rdat;
  logic [31:0]       q;
  logic              ack;
  logic              safe;
  logic              mute;
  logic              blind;
  muting_pkg::pins_t pins;
  int                num_errors = 0;
  int                cmp_count = 0;

  always #20 clk = ~clk;

  muting_sequencer #(.TICK_CYC(TICK)) u_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_entry_sensor_a(pins.sensor[0]), .i_entry_sensor_b(pins.sensor[1]),
    .i_exit_sensor_a(pins.sensor[2]), .i_exit_sensor_b(pins.sensor[3]),
    .i_curtain(pins.curtain), .i_enable(pins.enable), .o_safety_ok(safe),
    .o_muting_active(mute), .o_blind_active(blind));

  muting_field_model u_field (.i_clk(clk), .o_pins(pins));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk({31'h0, ack}, 32'h0000_0001);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic hold(input muting_pkg::pins_t p, input int n);
    u_field.put(p);
    repeat (n) @(posedge clk);
  endtask

  // Outputs settle three edges after a pin change
  task automatic step(input muting_pkg::pins_t p, input logic [2:0] exp);
    hold(p, 5);
    chk({29'h0, safe, mute, blind}, {29'h0, exp});
  endtask

  task automatic test_end(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h09C4_07D0);
    rd(8'h08, 32'h0000_0000);
    rd(8'h0C, 32'h0000_00FA);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    test_end("regs");
    wb(1'b1, 8'h00, 32'h0000_0080);
    hold(6'h10, 10);
    step(6'h11, 3'h4);
    step(6'h13, 3'h6);
    step(6'h03, 3'h6);
    step(6'h0C, 3'h6);
    step(6'h1C, 3'h5);
    step(6'h0C, 3'h5);
    hold(6'h0C, 520);
    step(6'h0C, 3'h0);
    test_end("concurrent");
    hold(6'h10, 10);
    wb(1'b1, 8'h00, 32'h0000_0100);
    hold(6'h11, 10);
    step(6'h13, 3'h4);
    hold(6'h10, 10);
    hold(6'h11, 400);
    step(6'h13, 3'h6);
    step(6'h10, 3'h4);
    wb(1'b1, 8'h00, 32'h0000_0000);
    hold(6'h10, 10);
    hold(6'h11, 4100);
    step(6'h13, 3'h4);
    hold(6'h01, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h4);
    wb(1'b1, 8'h08, 32'h0000_2710);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h6);
    step(6'h03, 3'h6);
    hold(6'h03, 20000);
    step(6'h03, 3'h0);
    wb(1'b1, 8'h08, 32'h0000_0000);
    test_end("timing");
    wb(1'b1, 8'h00, 32'h0000_0004);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h4);
    hold(6'h10, 10);
    u_field.arm();
    hold(6'h31, 10);
    step(6'h33, 3'h6);
    step(6'h13, 3'h4);
    wb(1'b1, 8'h00, 32'h0000_000C);
    hold(6'h10, 10);
    u_field.arm();
    hold(6'h31, 10);
    step(6'h33, 3'h6);
    step(6'h13, 3'h6);
    step(6'h10, 3'h4);
    test_end("enable");
    wb(1'b1, 8'h00, 32'h0000_0003);
    hold(6'h00, 10);
    hold(6'h01, 10);
    step(6'h03, 3'h0);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h6);
    step(6'h12, 3'h4);
    hold(6'h10, 10);
    test_end("t_mode");
    wb(1'b1, 8'h00, 32'h0000_0052);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h4);
    hold(6'h10, 10);
    hold(6'h18, 10);
    step(6'h1C, 3'h6);
    hold(6'h1E, 10);
    step(6'h0F, 3'h6);
    step(6'h13, 3'h6);
    step(6'h11, 3'h4);
    test_end("sequential");
    wb(1'b1, 8'h00, 32'h0000_0001);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h6);
    step(6'h02, 3'h6);
    step(6'h10, 3'h4);
    hold(6'h10, 10);
    hold(6'h11, 10);
    step(6'h13, 3'h6);
    step(6'h12, 3'h6);
    hold(6'h12, 4900);
    step(6'h12, 3'h6);
    hold(6'h12, 100);
    step(6'h12, 3'h4);
    test_end("l_mode");
    wb(1'b1, 8'h00, 32'h0000_0020);
    hold(6'h10, 10);
    hold(6'h14, 10);
    step(6'h1C, 3'h6);
    step(6'h10, 3'h4);
    rd(8'h10, 32'h0000_0201);
    test_end("two_way");
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
